// file: shared/bsx_pkg.sv
// constants and types for the branch / skip / bit execution unit
// assumes one core clock and the core's active-low asynchronous reset
package bsx_pkg;

    // status flag bit positions
    localparam int SF_C = 0;
    localparam int SF_Z = 1;
    localparam int SF_N = 2;
    localparam int SF_V = 3;
    localparam int SF_S = 4;
    localparam int SF_H = 5;
    localparam int SF_T = 6;
    localparam int SF_I = 7;

    // status flags after reset
    localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;

    // cycle counts per instruction class
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // program counter steps
    localparam logic [15:0] PC_SKIP1 = 16'h0002;
    localparam logic [15:0] PC_SKIP2 = 16'h0003;
    localparam logic [15:0] PC_NEXT = 16'h0001;

    // operations of the flag unit
    typedef enum logic [1:0] {
        FOP_NONE,
        FOP_CMP,
        FOP_ROR,
        FOP_ROL
    } bsx_fop_e;

    // sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } bsx_state_e;

endpackage : bsx_pkg

// file: shared/bsx_flag_if.sv
// carrier between the executor and its flag unit
// assumes both ends sit in the same clock domain
`timescale 1ns/1ns
interface bsx_flag_if;
    bsx_pkg::bsx_fop_e op; // operation selector
    logic [7:0] opa; // first operand
    logic [7:0] opb; // second operand
    logic [7:0] status_flags_register_in; // flags before
    logic [7:0] res; // byte result
    logic [7:0] status_flags_register_out; // flags after

    modport exec (output op, opa, opb, status_flags_register_in, input res, status_flags_register_out);
    modport unit (input op, opa, opb, status_flags_register_in, output res, status_flags_register_out);
endinterface : bsx_flag_if

// file: hw/bsx_flag_unit.sv
// combinational flag unit: compare with immediate and rotates through carry
// assumes the executor holds the status flags and samples status_flags_register_out itself
`timescale 1ns/1ns
module bsx_flag_unit (
    bsx_flag_if.unit fu
);
    // compare result, never stored
    wire [7:0] diff = fu.opa - fu.opb;
    // rotates move the old carry in at the far end
    wire [7:0] rr_res = {fu.status_flags_register_in[bsx_pkg::SF_C], fu.opa[7:1]};
    wire [7:0] rl_res = {fu.opa[6:0], fu.status_flags_register_in[bsx_pkg::SF_C]};
    // borrow and overflow terms for the compare
    wire cmp_c = (~fu.opa[7] & fu.opb[7]) | (fu.opb[7] & diff[7]) | (diff[7] & ~fu.opa[7]);
    wire cmp_h = (~fu.opa[3] & fu.opb[3]) | (fu.opb[3] & diff[3]) | (diff[3] & ~fu.opa[3]);
    wire cmp_v = (fu.opa[7] & ~fu.opb[7] & ~diff[7]) | (~fu.opa[7] & fu.opb[7] & diff[7]);

    // select result and rebuild flags; untouched flags pass through
    always_comb begin
        fu.res = fu.opa;
        fu.status_flags_register_out = fu.status_flags_register_in;
        case (fu.op)
            bsx_pkg::FOP_CMP: begin
                fu.res = diff;
                fu.status_flags_register_out[bsx_pkg::SF_Z] = (diff == 8'h00);
                fu.status_flags_register_out[bsx_pkg::SF_N] = diff[7];
                fu.status_flags_register_out[bsx_pkg::SF_V] = cmp_v;
                fu.status_flags_register_out[bsx_pkg::SF_C] = cmp_c;
                fu.status_flags_register_out[bsx_pkg::SF_H] = cmp_h;
                fu.status_flags_register_out[bsx_pkg::SF_S] = diff[7] ^ cmp_v;
            end
            bsx_pkg::FOP_ROR: begin
                fu.res = rr_res;
                fu.status_flags_register_out[bsx_pkg::SF_Z] = (rr_res == 8'h00);
                fu.status_flags_register_out[bsx_pkg::SF_N] = rr_res[7];
                fu.status_flags_register_out[bsx_pkg::SF_C] = fu.opa[0];
                fu.status_flags_register_out[bsx_pkg::SF_V] = rr_res[7] ^ fu.opa[0];
                fu.status_flags_register_out[bsx_pkg::SF_S] = fu.opa[0];
            end
            bsx_pkg::FOP_ROL: begin
                fu.res = rl_res;
                fu.status_flags_register_out[bsx_pkg::SF_Z] = (rl_res == 8'h00);
                fu.status_flags_register_out[bsx_pkg::SF_N] = rl_res[7];
                fu.status_flags_register_out[bsx_pkg::SF_C] = fu.opa[7];
                fu.status_flags_register_out[bsx_pkg::SF_V] = rl_res[7] ^ fu.opa[7];
                fu.status_flags_register_out[bsx_pkg::SF_S] = fu.opa[7];
            end
            default: begin
                fu.res = fu.opa;
            end
        endcase
    end
endmodule : bsx_flag_unit

// file: hw/bsx_exec.sv
// executor for branch, skip and bit instructions of an 8-bit core
// assumes fetch presents one 16-bit word plus its own address, and a
// register file and I/O space that answer reads in the same cycle
`timescale 1ns/1ns
module bsx_exec (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [15:0] pc,
    input wire logic next_two_word,
    output logic ready,
    output logic [4:0] rd_addr,
    output logic [4:0] rr_addr,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] rr_data,
    input wire logic [15:0] z_ptr,
    output logic [4:0] io_raddr,
    input wire logic [7:0] io_rdata,
    output logic reg_we,
    output logic [4:0] reg_waddr,
    output logic [7:0] reg_wdata,
    output logic io_we,
    output logic [4:0] io_waddr,
    output logic [7:0] io_wdata,
    output logic pc_load,
    output logic [15:0] pc_target,
    output logic push_we,
    output logic [15:0] push_data,
    output logic [7:0] status_flags_register,
    output logic done
);

    // pick one bit of a byte; used for registers, I/O and flags
    function automatic logic bit_of(input logic [7:0] v, input logic [2:0] idx);
        return v[idx];
    endfunction : bit_of

    // force one bit of a byte to a value
    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx,
                                           input logic val);
        logic [7:0] r;
        r = v;
        r[idx] = val;
        return r;
    endfunction : put_bit

    // sequencer and result registers
    bsx_pkg::bsx_state_e state_q, state_d;
    logic [1:0] cnt_q, cnt_d; // cycles still to run after this one
    logic [7:0] status_flags_register_q, status_flags_register_d; // status flags
    logic done_q; // last cycle finished
    logic reg_we_q; // register write pulse
    logic [4:0] reg_waddr_q;
    logic [7:0] reg_wdata_q;
    logic io_we_q; // I/O write pulse
    logic [4:0] io_waddr_q;
    logic [7:0] io_wdata_q;
    logic pc_load_q; // flow change pulse
    logic [15:0] pc_target_q;
    logic push_we_q; // return address push pulse
    logic [15:0] push_data_q;

    // flag unit carrier
    bsx_flag_if fif ();

    // opcode classes
    wire is_indirect_call = (instr == 16'h9509);
    wire is_compare_skip_equal = (instr[15:10] == 6'h04);
    wire is_cpi = (instr[15:12] == 4'h3);
    wire is_skip_reg_bit_clear = (instr[15:9] == 7'h7e) && !instr[3];
    wire is_skip_reg_bit_set = (instr[15:9] == 7'h7f) && !instr[3];
    wire is_io = (instr[15:10] == 6'h26);
    wire is_ioskip = is_io && instr[8]; // bit 9 gives the tested level
    wire is_iomod = is_io && !instr[8]; // bit 9 gives the forced level
    wire is_brb = (instr[15:11] == 5'h1e); // bit 10 set means branch-on-clear
    wire is_ror = (instr[15:9] == 7'h4a) && (instr[3:0] == 4'h7);
    wire is_rol = (instr[15:10] == 6'h07) && (instr[8:4] == {instr[9], instr[3:0]});
    wire is_bflag = (instr[15:8] == 8'h94) && (instr[3:0] == 4'h8);
    wire is_bst = (instr[15:9] == 7'h7d) && !instr[3];
    wire is_bld = (instr[15:9] == 7'h7c) && !instr[3];

    // operand fields
    wire [2:0] bsel = instr[2:0]; // bit index b, also flag index s
    wire [7:0] imm_k = {instr[11:8], instr[3:0]};
    wire [15:0] br_off = {{9{instr[9]}}, instr[9:3]};
    wire [2:0] flag_sel = instr[6:4];

    // register and I/O read addresses, decoded straight from the word
    assign rd_addr = is_cpi ? {1'b1, instr[7:4]} : instr[8:4];
    assign rr_addr = {instr[9], instr[3:0]};
    assign io_raddr = instr[7:3];

    // accept only when idle; fetch must hold the word until taken
    assign ready = (state_q == bsx_pkg::ST_IDLE);
    wire accept = instr_valid && ready;

    // skip decision; the I/O test compares against the level in bit 9
    wire reg_bit = bit_of(rd_data, bsel);
    wire io_bit = bit_of(io_rdata, bsel);
    wire skip_hit = (is_compare_skip_equal && (rd_data == rr_data))
                  | (is_skip_reg_bit_clear && !reg_bit)
                  | (is_skip_reg_bit_set && reg_bit)
                  | (is_ioskip && (io_bit == instr[9]));
    wire [15:0] skip_tgt = pc + (next_two_word ? bsx_pkg::PC_SKIP2 : bsx_pkg::PC_SKIP1);

    // branch decision; the named aliases are fixed choices of s
    wire br_flag = bit_of(status_flags_register_q, bsel);
    wire br_taken = is_brb && (br_flag != instr[10]);
    // same test covers carry, half carry, I, T and V forms
    // the alias encodings select only s and polarity
    wire [15:0] br_tgt = pc + br_off + bsx_pkg::PC_NEXT;

    // cycle count of the accepted instruction
    logic [1:0] ncyc;
    always_comb begin
        ncyc = bsx_pkg::CYC_ONE;
        if (is_indirect_call) begin
            ncyc = bsx_pkg::CYC_THREE;
        end else if (skip_hit) begin
            ncyc = next_two_word ? bsx_pkg::CYC_THREE : bsx_pkg::CYC_TWO;
        end else if (br_taken || is_iomod) begin
            ncyc = bsx_pkg::CYC_TWO;
        end
    end

    // flag unit request
    always_comb begin
        fif.op = bsx_pkg::FOP_NONE;
        if (is_cpi) begin
            fif.op = bsx_pkg::FOP_CMP;
        end else if (is_ror) begin
            fif.op = bsx_pkg::FOP_ROR;
        end else if (is_rol) begin
            fif.op = bsx_pkg::FOP_ROL;
        end
    end
    assign fif.opa = rd_data;
    assign fif.opb = imm_k;
    assign fif.status_flags_register_in = status_flags_register_q;

    bsx_flag_unit u_flag (
        .fu(fif.unit)
    );

    // next flags: only the accepted instruction may touch them
    always_comb begin
        status_flags_register_d = status_flags_register_q;
        if (accept) begin
            if (is_cpi || is_ror || is_rol) begin
                status_flags_register_d = fif.status_flags_register_out;
            end else if (is_bst) begin
                status_flags_register_d = put_bit(status_flags_register_q, 3'(bsx_pkg::SF_T), reg_bit);
            end else if (is_bflag) begin
                status_flags_register_d = put_bit(status_flags_register_q, flag_sel, !instr[7]);
            end
        end
    end

    // sequencer: the accept cycle is the first of the count
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            bsx_pkg::ST_IDLE: begin
                if (accept && (ncyc != bsx_pkg::CYC_ONE)) begin
                    state_d = bsx_pkg::ST_BUSY;
                    cnt_d = ncyc - bsx_pkg::CYC_ONE;
                end
            end
            bsx_pkg::ST_BUSY: begin
                cnt_d = cnt_q - bsx_pkg::CYC_ONE;
                if (cnt_q == bsx_pkg::CYC_ONE) begin
                    state_d = bsx_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = bsx_pkg::ST_IDLE;
                cnt_d = 2'h0;
            end
        endcase
    end

    // done marks the cycle in which a new word may be taken again
    wire done_d = (accept && (ncyc == bsx_pkg::CYC_ONE))
                | ((state_q == bsx_pkg::ST_BUSY) && (cnt_q == bsx_pkg::CYC_ONE));

    // write-back values
    wire wr_reg = accept && (is_ror || is_rol || is_bld);
    wire [7:0] wr_val = is_bld ? put_bit(rd_data, bsel, status_flags_register_q[bsx_pkg::SF_T])
                               : fif.res;
    wire [7:0] io_val = put_bit(io_rdata, bsel, instr[9]);
    wire flow = accept && (is_indirect_call || skip_hit || br_taken);
    wire [15:0] flow_tgt = is_indirect_call ? z_ptr : (skip_hit ? skip_tgt : br_tgt);

    // sequencer and flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= bsx_pkg::ST_IDLE;
            cnt_q <= 2'h0;
            status_flags_register_q <= bsx_pkg::STATUS_FLAGS_REGISTER_RST;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            status_flags_register_q <= status_flags_register_d;
            done_q <= done_d;
        end
    end

    // register and I/O write pulses, one cycle after accept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_we_q <= 1'b0;
            reg_waddr_q <= 5'h00;
            reg_wdata_q <= 8'h00;
            io_we_q <= 1'b0;
            io_waddr_q <= 5'h00;
            io_wdata_q <= 8'h00;
        end else begin
            reg_we_q <= wr_reg;
            reg_waddr_q <= rd_addr;
            reg_wdata_q <= wr_val;
            io_we_q <= accept && is_iomod;
            io_waddr_q <= io_raddr;
            io_wdata_q <= io_val;
        end
    end

    // flow change and return push, one cycle after accept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_load_q <= 1'b0;
            pc_target_q <= 16'h0000;
            push_we_q <= 1'b0;
            push_data_q <= 16'h0000;
        end else begin
            pc_load_q <= flow;
            pc_target_q <= flow_tgt;
            push_we_q <= accept && is_indirect_call;
            push_data_q <= pc + bsx_pkg::PC_NEXT;
        end
    end

    // outputs
    assign reg_we = reg_we_q;
    assign reg_waddr = reg_waddr_q;
    assign reg_wdata = reg_wdata_q;
    assign io_we = io_we_q;
    assign io_waddr = io_waddr_q;
    assign io_wdata = io_wdata_q;
    assign pc_load = pc_load_q;
    assign pc_target = pc_target_q;
    assign push_we = push_we_q;
    assign push_data = push_data_q;
    assign status_flags_register = status_flags_register_q;
    assign done = done_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence seq_end2;
        !ready ##1 (ready && done_q);
    endsequence
    sequence seq_end3;
        !ready ##1 seq_end2;
    endsequence

    AST_INDIRECT_CALL: assert property (accept && is_indirect_call |=> push_we_q && pc_load_q
        && pc_target_q == $past(z_ptr) && status_flags_register_q == $past(status_flags_register_q) ##0 seq_end3)
        else $error("indirect call wrong");
    AST_COMPARE_SKIP_EQUAL: assert property (accept && is_compare_skip_equal && rd_data == rr_data && !next_two_word
        |=> pc_load_q && pc_target_q == $past(pc) + 16'h2 ##0 seq_end2)
        else $error("compare skip wrong");
    AST_CPI: assert property (accept && is_cpi |=> done_q && !reg_we_q
        && status_flags_register_q[bsx_pkg::SF_Z] == ($past(rd_data) == $past(imm_k)))
        else $error("compare immediate wrong");
    AST_SKIP_REG_BIT_CLEAR: assert property (accept && is_skip_reg_bit_clear && !reg_bit && next_two_word
        |=> pc_target_q == $past(pc) + 16'h3 ##0 seq_end3)
        else $error("register bit clear skip wrong");
    AST_SKIP_REG_BIT_SET: assert property (accept && is_skip_reg_bit_set && !reg_bit
        |=> done_q && !pc_load_q && ready)
        else $error("register bit set skip wrong");
    AST_IOSKIP: assert property (accept && is_ioskip && io_bit != instr[9]
        |=> done_q && !pc_load_q)
        else $error("io skip wrong");
    AST_BR_NT: assert property (accept && is_brb && !br_taken
        |=> done_q && !pc_load_q && status_flags_register_q == $past(status_flags_register_q))
        else $error("branch not taken wrong");
    AST_BR_T: assert property (accept && br_taken
        |=> pc_target_q == $past(pc) + $past(br_off) + 16'h1 ##0 seq_end2)
        else $error("branch taken wrong");
    AST_IOMOD: assert property (accept && is_iomod |=> io_we_q
        && bit_of(io_wdata_q, $past(bsel)) == $past(instr[9]) ##0 seq_end2)
        else $error("io bit write wrong");
    AST_ROR: assert property (accept && is_ror |=> reg_we_q
        && reg_wdata_q == {$past(status_flags_register_q[bsx_pkg::SF_C]), $past(rd_data[7:1])}
        && status_flags_register_q[bsx_pkg::SF_C] == $past(rd_data[0]))
        else $error("rotate right wrong");
    AST_ROL: assert property (accept && is_rol |=> reg_we_q
        && reg_wdata_q[0] == $past(status_flags_register_q[bsx_pkg::SF_C])
        && status_flags_register_q[bsx_pkg::SF_C] == $past(rd_data[7]))
        else $error("rotate left wrong");
    AST_BST: assert property (accept && is_bst |=> !reg_we_q
        && status_flags_register_q[bsx_pkg::SF_T] == $past(reg_bit))
        else $error("bit store wrong");
    AST_BLD: assert property (accept && is_bld |=> reg_we_q
        && status_flags_register_q == $past(status_flags_register_q)
        && bit_of(reg_wdata_q, $past(bsel)) == $past(status_flags_register_q[bsx_pkg::SF_T]))
        else $error("bit load wrong");
    AST_BFLAG: assert property (accept && is_bflag |=> done_q
        && bit_of(status_flags_register_q, $past(flag_sel)) == !$past(instr[7])
        && (status_flags_register_q ^ $past(status_flags_register_q)) == (($past(status_flags_register_q) ^ status_flags_register_q) & (8'h01 << $past(flag_sel))))
        else $error("flag set clear wrong");

endmodule : bsx_exec

// file: sim/bsx_exec_test.sv
// self-checking bench for the branch / skip / bit executor
// assumes a same-cycle register file and I/O space, modelled here by arrays
`timescale 1ns/1ns
module bsx_exec_test;
    logic clk = 1'b0; // core clock, 8 ns
    logic reset_n = 1'b0; // active-low reset
    logic instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [15:0] pc = 16'h0000;
    logic next_two_word = 1'b0;
    logic [15:0] z_ptr = 16'h1234; // indirect call target
    logic ready, reg_we, io_we, pc_load, push_we, done;
    logic [4:0] rd_addr, rr_addr, io_raddr, reg_waddr, io_waddr;
    logic [7:0] reg_wdata, io_wdata, status_flags_register;
    logic [15:0] pc_target, push_data;
    logic [7:0] regs [32]; // register file model
    logic [7:0] iom [32]; // I/O space model
    logic [7:0] sf; // expected status flags
    int failures = 0;
    int check_count = 0;
    int cyc; // cycles seen for the last instruction
    logic pcl, psh, rwe, iwe; // pulses seen
    logic [15:0] tgt, pdat;
    logic [7:0] rwd, iwd;
    logic [4:0] rwa, iwa;

    // reads answer in the same cycle, as the executor expects
    wire [7:0] rd_data = regs[rd_addr];
    wire [7:0] rr_data = regs[rr_addr];
    wire [7:0] io_rdata = iom[io_raddr];

    always #4 clk = ~clk;

    bsx_exec bsx_exec_i (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr(instr), .pc(pc), .next_two_word(next_two_word), .ready(ready),
        .rd_addr(rd_addr), .rr_addr(rr_addr), .rd_data(rd_data), .rr_data(rr_data),
        .z_ptr(z_ptr), .io_raddr(io_raddr), .io_rdata(io_rdata), .reg_we(reg_we),
        .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .io_we(io_we),
        .io_waddr(io_waddr), .io_wdata(io_wdata), .pc_load(pc_load),
        .pc_target(pc_target), .push_we(push_we), .push_data(push_data),
        .status_flags_register(status_flags_register), .done(done));

    // ends the run with the counts and the verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // one comparison, four-state exact
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // issue one instruction and collect every pulse until done
    task automatic run(input logic [15:0] ins, input logic [15:0] p, input logic ntw);
        int n;
        n = 0;
        cyc = 0;
        {pcl, psh, rwe, iwe} = 4'h0;
        @(negedge clk);
        check(ready, 1'b1);
        instr = ins;
        pc = p;
        next_two_word = ntw;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
        // bounded wait: no instruction here exceeds 3 cycles
        repeat (8) begin
            if (cyc == 0) begin
                n++;
                if (pc_load === 1'b1) begin
                    pcl = 1'b1;
                    tgt = pc_target;
                end
                if (push_we === 1'b1) begin
                    psh = 1'b1;
                    pdat = push_data;
                end
                if (reg_we === 1'b1) begin
                    rwe = 1'b1;
                    {rwa, rwd} = {reg_waddr, reg_wdata};
                end
                if (io_we === 1'b1) begin
                    iwe = 1'b1;
                    {iwa, iwd} = {io_waddr, io_wdata};
                end
                if (done === 1'b1) cyc = n;
                else @(negedge clk);
            end
        end
        if (cyc == 0) begin
            failures++;
            $display("[FAIL] %0t instruction never completed", $time);
            print_verdict();
        end
    endtask : run

    // set or clear one flag through its dedicated instruction
    task automatic flag_op(input int s, input logic v);
        run((v ? 16'h9408 : 16'h9488) | 16'(s << 4), 16'h0010, 1'b0);
        sf[s] = v;
        check(status_flags_register, sf);
        check(16'(cyc), 16'h1);
    endtask : flag_op

    // conditional branch at pc 0x0100, taken or falling through
    task automatic branch(input logic [15:0] ins, input logic tk, input logic [15:0] t);
        run(ins, 16'h0100, 1'b0);
        check(16'(cyc), tk ? 16'h2 : 16'h1);
        check(pcl, tk);
        if (tk) check(tgt, t);
        check(status_flags_register, sf);
    endtask : branch

    // skip test at pc 0x0200 over a one- or two-word follower
    task automatic skip_chk(input logic [15:0] ins, input logic sk, input logic ntw);
        run(ins, 16'h0200, ntw);
        check(16'(cyc), sk ? (ntw ? 16'h3 : 16'h2) : 16'h1);
        check(pcl, sk);
        if (sk) check(tgt, ntw ? 16'h0203 : 16'h0202);
        check(status_flags_register, sf);
    endtask : skip_chk

    // expected flags of a compare: result is discarded, T and I kept
    function automatic logic [7:0] cmp_sf(logic [7:0] a, logic [7:0] b, logic [7:0] f);
        logic [7:0] r;
        r = a - b;
        f[0] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        f[1] = (r == 8'h00);
        f[2] = r[7];
        f[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        f[4] = f[2] ^ f[3];
        f[5] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        return f;
    endfunction : cmp_sf

    // rotate through carry on register rn, write-back and flags compared
    task automatic rot_chk(input logic [15:0] ins, input int rn, input logic left);
        logic [7:0] a;
        logic [7:0] r;
        a = regs[rn];
        r = left ? {a[6:0], sf[0]} : {sf[0], a[7:1]};
        sf[0] = left ? a[7] : a[0];
        sf[1] = (r == 8'h00);
        sf[2] = r[7];
        sf[3] = sf[2] ^ sf[0];
        sf[4] = sf[2] ^ sf[3];
        run(ins, 16'h0400, 1'b0);
        check({rwe, 2'h0, rwa, rwd}, {1'b1, 2'h0, 5'(rn), r});
        check(status_flags_register, sf);
        check(16'(cyc), 16'h1);
    endtask : rot_chk

    // main sequence
    initial begin
        logic [15:0] sk_ins [8];
        logic sk_exp [8];
        for (int i = 0; i < 32; i++) begin
            regs[i] = 8'(i * 8'h11);
            iom[i] = 8'h00;
        end
        sf = 8'h00;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        check(status_flags_register, 8'h00);
        check({ready, done, pc_load, reg_we, io_we, push_we}, 6'h20);
        $display("test reset done");

        // every flag cleared and set, branches on each both ways
        for (int s = 0; s < 8; s++) begin
            for (int v = 0; v < 2; v++) begin
                flag_op(s, v[0]);
                branch(16'hf3e8 | 16'(s), v == 1, 16'h00fe);
                branch(16'hf428 | 16'(s), v == 0, 16'h0106);
            end
        end
        $display("test flags and branches done");

        // compares feed the signed, unsigned and zero branches
        regs[17] = 8'h80;
        regs[18] = 8'h10;
        regs[19] = 8'h42;
        run(16'h3011, 16'h0020, 1'b0);
        sf = cmp_sf(8'h80, 8'h01, sf);
        check(status_flags_register, sf);
        check(16'(cyc), 16'h1);
        branch(16'hf3ec, 1'b1, 16'h00fe);
        branch(16'hf42c, 1'b0, 16'h0106);
        branch(16'hf42b, 1'b0, 16'h0106);
        run(16'h3220, 16'h0020, 1'b0);
        sf = cmp_sf(8'h10, 8'h20, sf);
        check(status_flags_register, sf);
        branch(16'hf3e8, 1'b1, 16'h00fe);
        branch(16'hf428, 1'b0, 16'h0106);
        branch(16'hf42c, 1'b0, 16'h0106);
        run(16'h3432, 16'h0020, 1'b0);
        sf = cmp_sf(8'h42, 8'h42, sf);
        check(status_flags_register, sf);
        branch(16'hf3e9, 1'b1, 16'h00fe);
        branch(16'hf42d, 1'b1, 16'h0106);
        $display("test compare done");

        // skips over one- and two-word followers
        regs[1] = 8'h5a;
        regs[2] = 8'h5a;
        regs[3] = 8'h5b;
        regs[4] = 8'hf7;
        iom[5] = 8'h02;
        sk_ins = '{16'h1012, 16'h1013, 16'hfc43, 16'hfe43,
                   16'hfe42, 16'hfc42, 16'h9b29, 16'h9928};
        sk_exp = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 8; i++) begin
            skip_chk(sk_ins[i], sk_exp[i], 1'b0);
            skip_chk(sk_ins[i], sk_exp[i], 1'b1);
        end
        skip_chk(16'h9929, 1'b0, 1'b1);
        skip_chk(16'h9b28, 1'b0, 1'b0);
        $display("test skips done");

        // indirect call pushes the return address and jumps to Z
        run(16'h9509, 16'h0300, 1'b0);
        check({psh, pdat}, {1'b1, 16'h0301});
        check({pcl, tgt}, {1'b1, 16'h1234});
        check(16'(cyc), 16'h3);
        check(status_flags_register, sf);
        $display("test indirect call done");

        // I/O bit set and clear write back the modified byte
        iom[7] = 8'h0f;
        run(16'h9a3c, 16'h0500, 1'b0);
        check({iwe, 2'h0, iwa, iwd}, {1'b1, 2'h0, 5'h07, 8'h1f});
        check(16'(cyc), 16'h2);
        iom[7] = 8'hff;
        run(16'h983c, 16'h0500, 1'b0);
        check({iwe, 2'h0, iwa, iwd}, {1'b1, 2'h0, 5'h07, 8'hef});
        check({15'(cyc), rwe}, {15'h2, 1'b0});
        check(status_flags_register, sf);
        $display("test I/O bits done");

        // rotates through carry with carry set and clear
        regs[5] = 8'h81;
        flag_op(0, 1'b1);
        rot_chk(16'h9457, 5, 1'b0);
        regs[6] = 8'h80;
        flag_op(0, 1'b0);
        rot_chk(16'h1c66, 6, 1'b1);
        regs[6] = 8'h35;
        rot_chk(16'h1c66, 6, 1'b1);
        $display("test rotates done");

        // T flag store and load
        regs[8] = 8'h40;
        regs[9] = 8'h00;
        run(16'hfa86, 16'h0600, 1'b0);
        sf[6] = 1'b1;
        check(status_flags_register, sf);
        run(16'hf892, 16'h0600, 1'b0);
        check({rwe, 2'h0, rwa, rwd}, {1'b1, 2'h0, 5'h09, 8'h04});
        run(16'hfa85, 16'h0600, 1'b0);
        sf[6] = 1'b0;
        check(status_flags_register, sf);
        regs[9] = 8'hff;
        run(16'hf892, 16'h0600, 1'b0);
        check({rwe, 2'h0, rwa, rwd}, {1'b1, 2'h0, 5'h09, 8'hfb});
        check(status_flags_register, sf);
        $display("test T flag done");
        print_verdict();
    end
endmodule : bsx_exec_test
